// *** design/rmsr_clk_div.sv ***
/*
  Clock-output divider: divides the reference by a power of two, passes the
  RC oscillator through, or holds the pin low.
  Assumes the reference is the register clock, so ratio 1 appears at half
  the clock rate (one toggle per cycle) and each code halves from there.
*/
`timescale 1ns/100ps
`default_nettype none
module rmsr_clk_div
  import rmsr_pkg::*;
(
  // Clock and control
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // Select and clock output
  rmsr_clk_if.div cif
);
  logic [4:0] div_cnt;

  function automatic logic [4:0] div_mask(input logic [2:0] sel);
    div_mask = 5'((6'h01 << sel) - 6'h01);
  endfunction

  wire div_sel = (cif.sel <= CLK_SEL_MAX_DIV);
  wire div_tick = ((div_cnt & div_mask(cif.sel)) == div_mask(cif.sel));

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      div_cnt <= 5'h00;
      cif.clk_out <= 1'b0;
      cif.rc_en <= 1'b0;
    end else if (ce_in) begin
      div_cnt <= div_cnt + 5'h01;
      cif.rc_en <= (cif.sel == CLK_SEL_RC);
      if (cif.sel == CLK_SEL_RC) begin
        cif.clk_out <= cif.rc_osc;
      end else if (!div_sel) begin
        cif.clk_out <= 1'b0;
      end else if (div_tick) begin
        cif.clk_out <= ~cif.clk_out;
      end
    end
  end
endmodule
`default_nettype wire

// *** design/rmsr_clk_if.sv ***
/*
  Carrier between the register slice and its clock-output divider.
  Assumes both ends share the register clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface rmsr_clk_if;
  logic [2:0] sel;
  logic rc_osc;
  logic clk_out;
  logic rc_en;
  modport ctrl(output sel, output rc_osc, input clk_out, input rc_en);
  modport div(input sel, input rc_osc, output clk_out, output rc_en);
endinterface
`default_nettype wire

// *** design/rmsr_pkg.sv ***
/*
  Constants for the radio measurement and status register slice: register
  indices, field positions, values after reset, mode codes and timing.
  Assumes a 200 MHz register clock and a 32-bit AHB-Lite word per register.
*/
package rmsr_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_MODE = 8'h01;
  localparam logic [7:0] IDX_AFC_CTRL = 8'h1e;
  localparam logic [7:0] IDX_AFC_HI = 8'h1f;
  localparam logic [7:0] IDX_AFC_LO = 8'h20;
  localparam logic [7:0] IDX_FEI_HI = 8'h21;
  localparam logic [7:0] IDX_FEI_LO = 8'h22;
  localparam logic [7:0] IDX_LVL_CTRL = 8'h23;
  localparam logic [7:0] IDX_LVL_VALUE = 8'h24;
  localparam logic [7:0] IDX_ROUTE_A = 8'h25;
  localparam logic [7:0] IDX_ROUTE_B = 8'h26;
  localparam logic [7:0] IDX_FLAGS_A = 8'h27;
  localparam logic [7:0] IDX_THRESH = 8'h29;
  localparam logic [7:0] IDX_TO_START = 8'h2a;
  localparam logic [7:0] IDX_TO_POST = 8'h2b;

  // Field positions
  localparam int MODE_LSB = 2;
  localparam int FEI_DONE_BIT = 6;
  localparam int FEI_TRIG_BIT = 5;
  localparam int AFC_DONE_BIT = 4;
  localparam int AFC_TRIG_BIT = 0;
  localparam int LVL_DONE_BIT = 1;
  localparam int LVL_TRIG_BIT = 0;
  localparam int FLG_MODE_BIT = 7;
  localparam int FLG_RXRDY_BIT = 6;
  localparam int FLG_TXRDY_BIT = 5;
  localparam int FLG_LOCK_BIT = 4;
  localparam int FLG_LVL_BIT = 3;
  localparam int FLG_TO_BIT = 2;
  localparam int FLG_AUTO_BIT = 1;
  localparam int FLG_SYNC_BIT = 0;

  // Values after reset
  localparam logic [7:0] LVL_VALUE_RST = 8'hff;
  localparam logic [7:0] THRESH_RST = 8'he4;
  localparam logic [7:0] TO_RST = 8'h00;
  localparam logic [7:0] ROUTE_RST = 8'h00;
  localparam logic [15:0] MEAS_RST = 16'h0000;
  localparam logic [2:0] CLK_SEL_RST = 3'b111;

  // Clock-output select codes
  localparam logic [2:0] CLK_SEL_MAX_DIV = 3'b101;
  localparam logic [2:0] CLK_SEL_RC = 3'b110;
  localparam logic [2:0] CLK_SEL_OFF = 3'b111;

  typedef enum logic [2:0] {
    RMSR_SLEEP = 3'b000,
    RMSR_STANDBY = 3'b001,
    RMSR_SYNTH = 3'b010,
    RMSR_TX = 3'b011,
    RMSR_RX = 3'b100
  } rmsr_mode_t;

  // Timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int BIT_TIME_PS = 208333000;
  localparam int BIT_CYCLES_DEF = BIT_TIME_PS / CLK_PERIOD_PS;
  localparam int TO_BITS_SHIFT = 4;
endpackage

// *** design/rmsr_regs.sv ***
/*
  Radio measurement and status register slice behind an AHB-Lite slave:
  frequency correction and error results, level measurement, pin routing,
  clock-output select and the first event flag register.
  Assumes the radio core inputs are synchronous to clk_in and that
  measurement results arrive with a one-cycle valid strobe.
*/
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module rmsr_regs
  import rmsr_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYCLES_DEF
) (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Radio core status
  input wire logic xo_running_in,
  input wire logic pll_locked_in,
  input wire logic pa_ramp_done_in,
  input wire logic agc_done_in,
  input wire logic inter_mode_in,
  input wire logic packet_mode_in,
  input wire logic sync_detect_in,
  input wire logic fifo_empty_in,
  input wire logic payload_ready_in,
  input wire logic rc_osc_in,
  // Measurement results
  input wire logic [7:0] lvl_sample_in,
  input wire logic lvl_sample_valid_in,
  input wire logic [15:0] afc_result_in,
  input wire logic afc_result_valid_in,
  input wire logic [15:0] fei_result_in,
  input wire logic fei_result_valid_in,
  // Commands to the radio core
  output logic [2:0] mode_out,
  output logic afc_start_out,
  output logic fei_start_out,
  output logic lvl_start_out,
  // Pins
  output logic [5:0] gp_out_pin_out,
  output logic clock_out_pin_out,
  output logic rc_osc_enable_out
);
  rmsr_clk_if cif();

  rmsr_clk_div u_div (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .cif(cif)
  );

  // Register state
  rmsr_mode_t mode;
  logic [15:0] freq_corr_result;
  logic [15:0] freq_error_result;
  logic afc_done;
  logic fei_done;
  logic level_meas_done;
  logic [7:0] level_meas_value;
  logic [7:0] level_trip_point;
  logic [7:0] rx_start_timeout;
  logic [7:0] post_level_timeout;
  logic [7:0] pin_route_sel_a;
  logic [3:0] pin_route_sel_b;
  logic mode_usable_flag;
  logic receive_usable_flag;
  logic transmit_usable_flag;
  logic synth_locked_flag;
  logic level_flag;
  logic timeout_flag;
  logic intermediate_mode_flag;
  logic sync_matched_flag;
  logic rx_lvl_started;
  logic fifo_empty_prev;
  // Bus data phase
  logic dp_wr;
  logic [7:0] dp_idx;
  logic [7:0] next_rdata;
  // Timers
  logic [15:0] bit_cnt;
  logic [11:0] start_cnt;
  logic start_run;
  logic [11:0] post_cnt;
  logic post_run;

  function automatic logic route_src(input logic [1:0] sel,
                                     input logic [3:0] src);
    route_src = src[sel];
  endfunction

  // Address decode
  wire addr_ok = (haddr_in[31:10] == 22'h000000) && (haddr_in[1:0] == 2'b00);
  wire take = hsel_in && htrans_in[1] && hready_in;
  wire [7:0] a_idx = addr_ok ? haddr_in[9:2] : 8'h00;
  wire [7:0] wd = hwdata_in[7:0];
  wire wr_mode = dp_wr && (dp_idx == IDX_MODE);
  wire wr_afc = dp_wr && (dp_idx == IDX_AFC_CTRL);
  wire wr_lvl = dp_wr && (dp_idx == IDX_LVL_CTRL);
  wire wr_route_a = dp_wr && (dp_idx == IDX_ROUTE_A);
  wire wr_route_b = dp_wr && (dp_idx == IDX_ROUTE_B);
  wire wr_flags = dp_wr && (dp_idx == IDX_FLAGS_A);
  wire wr_thresh = dp_wr && (dp_idx == IDX_THRESH);
  wire wr_to_start = dp_wr && (dp_idx == IDX_TO_START);
  wire wr_to_post = dp_wr && (dp_idx == IDX_TO_POST);

  // Mode tracking
  wire [2:0] wr_mode_code = wd[MODE_LSB +: 3];
  wire mode_code_ok = (wr_mode_code <= RMSR_RX);
  wire mode_chg = wr_mode && mode_code_ok && (wr_mode_code != mode);
  wire in_rx = (mode == RMSR_RX);
  wire in_tx = (mode == RMSR_TX);
  wire rx_entry = mode_chg && (wr_mode_code == RMSR_RX);
  wire rx_leave = mode_chg && in_rx;
  wire synth_on = (mode == RMSR_SYNTH) || in_rx || in_tx;

  // Triggers
  wire afc_go = wr_afc && wd[AFC_TRIG_BIT];
  wire fei_go = wr_afc && wd[FEI_TRIG_BIT];
  wire lvl_go = (wr_lvl && wd[LVL_TRIG_BIT]) || rx_entry;

  // Flag causes
  logic mode_ready_cond;
  always_comb begin
    case (mode)
      RMSR_SLEEP: mode_ready_cond = 1'b1;
      RMSR_STANDBY: mode_ready_cond = xo_running_in;
      RMSR_SYNTH: mode_ready_cond = pll_locked_in;
      RMSR_TX: mode_ready_cond = pa_ramp_done_in;
      RMSR_RX: mode_ready_cond = rx_lvl_started;
      default: mode_ready_cond = 1'b0;
    endcase
  end
  wire lvl_above = in_rx && level_meas_done &&
                   (level_meas_value > level_trip_point);
  wire lvl_event = lvl_above && !level_flag;
  wire fifo_emptied = fifo_empty_in && !fifo_empty_prev;
  wire bit_tick = (bit_cnt == 16'(BIT_CYCLES - 1));
  wire start_fire = start_run && bit_tick &&
                    (start_cnt + 12'h001 ==
                     {rx_start_timeout, 4'h0});
  wire post_fire = post_run && bit_tick &&
                   (post_cnt + 12'h001 == {post_level_timeout, 4'h0});
  wire sync_w1c = wr_flags && wd[FLG_SYNC_BIT] && !packet_mode_in;

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      dp_wr <= 1'b0;
      dp_idx <= 8'h00;
      hrdata_out <= 32'h00000000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else if (ce_in) begin
      dp_wr <= take && hwrite_in;
      dp_idx <= a_idx;
      if (take && !hwrite_in) begin
        hrdata_out <= {24'h000000, next_rdata};
      end
    end
  end

  // Read selection; unused bits and unmapped indices read zero
  always_comb begin
    case (a_idx)
      IDX_MODE: next_rdata = {3'b000, mode, 2'b00};
      IDX_AFC_CTRL: next_rdata = {1'b0, fei_done, 1'b0, afc_done,
                                  4'h0};
      IDX_AFC_HI: next_rdata = freq_corr_result[15:8];
      IDX_AFC_LO: next_rdata = freq_corr_result[7:0];
      IDX_FEI_HI: next_rdata = freq_error_result[15:8];
      IDX_FEI_LO: next_rdata = freq_error_result[7:0];
      IDX_LVL_CTRL: next_rdata = {6'h00, level_meas_done,
                                  1'b0};
      IDX_LVL_VALUE: next_rdata = level_meas_value;
      IDX_ROUTE_A: next_rdata = pin_route_sel_a;
      IDX_ROUTE_B: next_rdata = {pin_route_sel_b, 1'b0, cif.sel};
      IDX_FLAGS_A: next_rdata = {mode_usable_flag, receive_usable_flag,
                                 transmit_usable_flag, synth_locked_flag,
                                 level_flag, timeout_flag,
                                 intermediate_mode_flag, sync_matched_flag};
      IDX_THRESH: next_rdata = level_trip_point;
      IDX_TO_START: next_rdata = rx_start_timeout;
      IDX_TO_POST: next_rdata = post_level_timeout;
      default: next_rdata = 8'h00;
    endcase
  end

  // Writable settings
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mode <= RMSR_STANDBY;
      pin_route_sel_a <= ROUTE_RST;
      pin_route_sel_b <= ROUTE_RST[3:0];
      cif.sel <= CLK_SEL_RST;
      level_trip_point <= THRESH_RST;
      rx_start_timeout <= TO_RST;
      post_level_timeout <= TO_RST;
    end else if (ce_in) begin
      if (mode_chg) begin
        mode <= rmsr_mode_t'(wr_mode_code);
      end
      if (wr_route_a) begin
        pin_route_sel_a <= wd;
      end
      if (wr_route_b) begin
        pin_route_sel_b <= wd[7:4];
        cif.sel <= wd[2:0];
      end
      if (wr_thresh) begin
        level_trip_point <= wd;
      end
      if (wr_to_start) begin
        rx_start_timeout <= wd;
      end
      if (wr_to_post) begin
        post_level_timeout <= wd;
      end
    end
  end

  // Measurements; result registers are never written by the bus
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      freq_corr_result <= MEAS_RST;
      freq_error_result <= MEAS_RST;
      afc_done <= 1'b1;
      fei_done <= 1'b1;
      level_meas_done <= 1'b1;
      level_meas_value <= LVL_VALUE_RST;
      afc_start_out <= 1'b0;
      fei_start_out <= 1'b0;
      lvl_start_out <= 1'b0;
    end else if (ce_in) begin
      afc_start_out <= afc_go;
      fei_start_out <= fei_go;
      lvl_start_out <= lvl_go;
      if (afc_go) begin
        afc_done <= 1'b0;
      end else if (afc_result_valid_in) begin
        afc_done <= 1'b1;
        freq_corr_result <= afc_result_in;
      end
      if (fei_go) begin
        fei_done <= 1'b0;
      end else if (fei_result_valid_in) begin
        fei_done <= 1'b1;
        freq_error_result <= fei_result_in;
      end
      if (lvl_go) begin
        level_meas_done <= 1'b0;
      end else if (lvl_sample_valid_in) begin
        level_meas_done <= 1'b1;
        level_meas_value <= lvl_sample_in;
      end
    end
  end

  // Event flags; a set beats a same-cycle clear, except that a mode change beats the mode, level and sync sets
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mode_usable_flag <= 1'b1;
      receive_usable_flag <= 1'b0;
      transmit_usable_flag <= 1'b0;
      synth_locked_flag <= 1'b0;
      level_flag <= 1'b0;
      timeout_flag <= 1'b0;
      intermediate_mode_flag <= 1'b0;
      sync_matched_flag <= 1'b0;
      rx_lvl_started <= 1'b0;
      fifo_empty_prev <= 1'b1;
    end else if (ce_in) begin
      fifo_empty_prev <= fifo_empty_in;
      rx_lvl_started <= in_rx && !rx_leave &&
                        (rx_lvl_started || lvl_start_out);
      if (mode_chg) begin
        mode_usable_flag <= 1'b0;
      end else if (mode_ready_cond) begin
        mode_usable_flag <= 1'b1;
      end
      receive_usable_flag <= in_rx && !rx_leave && rx_lvl_started &&
                             level_meas_done && agc_done_in &&
                             afc_done;
      transmit_usable_flag <= in_tx && !mode_chg &&
                              pa_ramp_done_in;
      synth_locked_flag <= synth_on && pll_locked_in;
      intermediate_mode_flag <= inter_mode_in;
      if (lvl_above && !rx_leave) begin
        level_flag <= 1'b1;
      end else if (rx_leave || (wr_flags && wd[FLG_LVL_BIT])) begin
        level_flag <= 1'b0;
      end
      if (start_fire || post_fire) begin
        timeout_flag <= 1'b1;
      end else if (rx_leave || fifo_emptied) begin
        timeout_flag <= 1'b0;
      end
      if (sync_detect_in && in_rx && !rx_leave) begin
        sync_matched_flag <= 1'b1;
      end else if (rx_leave || fifo_emptied || sync_w1c) begin
        sync_matched_flag <= 1'b0;
      end
    end
  end

  // Receive timeouts; bit periods restart on receive entry
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      bit_cnt <= 16'h0000;
      start_cnt <= 12'h000;
      start_run <= 1'b0;
      post_cnt <= 12'h000;
      post_run <= 1'b0;
    end else if (ce_in) begin
      bit_cnt <= (rx_entry || bit_tick) ? 16'h0000 : bit_cnt + 16'h0001;
      if (rx_entry) begin
        start_run <= (rx_start_timeout != TO_RST);
        start_cnt <= 12'h000;
      end else if (!in_rx || lvl_event || level_flag || start_fire) begin
        start_run <= 1'b0;
      end else if (start_run && bit_tick) begin
        start_cnt <= start_cnt + 12'h001;
      end
      if (lvl_event && !rx_leave) begin
        post_run <= (post_level_timeout != TO_RST);
        post_cnt <= 12'h000;
      end else if (!in_rx || rx_leave || payload_ready_in || post_fire) begin
        post_run <= 1'b0;
      end else if (post_run && bit_tick) begin
        post_cnt <= post_cnt + 12'h001;
      end
    end
  end

  // Pin routing: 00 sync, 01 level, 10 timeout, 11 mode usable
  wire [3:0] route_srcs = {mode_usable_flag, timeout_flag, level_flag,
                           sync_matched_flag};
  wire [11:0] pin_sels = {pin_route_sel_b, pin_route_sel_a};
  wire [5:0] next_gp = {route_src(pin_sels[7:6], route_srcs),
                        route_src(pin_sels[5:4], route_srcs),
                        route_src(pin_sels[1:0], route_srcs),
                        route_src(pin_sels[3:2], route_srcs),
                        route_src(pin_sels[5:4], route_srcs),
                        route_src(pin_sels[7:6], route_srcs)};

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      gp_out_pin_out <= 6'h00;
      mode_out <= RMSR_STANDBY;
    end else if (ce_in) begin
      gp_out_pin_out <= {route_src(pin_sels[9:8], route_srcs),
                         route_src(pin_sels[11:10], route_srcs),
                         next_gp[3], next_gp[2],
                         next_gp[4], next_gp[5]};
      mode_out <= mode;
    end
  end

  assign cif.rc_osc = rc_osc_in;
  assign clock_out_pin_out = cif.clk_out;
  assign rc_osc_enable_out = cif.rc_en;
endmodule
`default_nettype wire

// *** sim/rmsr_meas_model.sv ***
/* Radio core measurement model: a start pulse is answered by a one-cycle
   result strobe DLY cycles later. Assumes the register clock. */
`timescale 1ns/100ps
`default_nettype none
module rmsr_meas_model #(
  parameter int DLY = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Start and result
  input wire logic start_in,
  input wire logic [15:0] value_in,
  output logic [15:0] result_out,
  output logic valid_out
);
  int cnt;
  // Off the strobe the bus shows the inverse, never a stale result
  assign result_out = valid_out ? value_in : ~value_in;
  always_ff @(posedge clk_in) begin
    if (reset_in || start_in)
      cnt <= reset_in ? 0 : DLY;
    else if (cnt > 0)
      cnt <= cnt - 1;
    valid_out <= !reset_in && cnt == 1;
  end
endmodule
`default_nettype wire

// *** sim/rmsr_regs_sva.sv ***
/* Checker on the slice ports: read width, trigger pulses, mode writes.
   Assumes it is bound into rmsr_regs on a zero-wait bus. */
`timescale 1ns/100ps
`default_nettype none
module rmsr_regs_sva
  import rmsr_pkg::*;
(
  // Clock, reset, bus
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  // Core commands
  input wire logic [2:0] mode_out,
  input wire logic afc_start_out,
  input wire logic fei_start_out,
  input wire logic lvl_start_out
);
  logic dp_wr;
  logic [7:0] dp_idx;
  wire logic wr_end = dp_wr && ce_in && hready_in;
  // Writes land at the edge closing the data phase
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      dp_wr <= 1'b0;
      dp_idx <= 8'h00;
    end else if (ce_in && hready_in) begin
      dp_wr <= hsel_in && htrans_in[1] && hwrite_in;
      dp_idx <= haddr_in[9:2];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence s_trig(idx, b);
    wr_end && dp_idx == idx && hwdata_in[b];
  endsequence
  a_rd_upper_zero:
    assert property (hrdata_out[31:8] == 24'h0)
    else $error("upper read bits set");
  a_afc_start:
    assert property (s_trig(IDX_AFC_CTRL, AFC_TRIG_BIT) |-> ##[1:2] afc_start_out)
    else $error("correction start missing");
  a_fei_start:
    assert property (s_trig(IDX_AFC_CTRL, FEI_TRIG_BIT) |-> ##[1:2] fei_start_out)
    else $error("error start missing");
  a_lvl_start:
    assert property (s_trig(IDX_LVL_CTRL, LVL_TRIG_BIT) |-> ##[1:2] lvl_start_out)
    else $error("level start missing");
  a_afc_single:
    assert property (afc_start_out |=> !afc_start_out)
    else $error("correction start too long");
  a_lvl_single:
    assert property (lvl_start_out |=> !lvl_start_out)
    else $error("level start too long");
  a_rx_level:
    assert property ($changed(mode_out) && mode_out == RMSR_RX
      |-> $past(lvl_start_out)) else $error("no level run on rx entry");
  a_mode_write:
    assert property (wr_end && dp_idx == IDX_MODE && hwdata_in[4:2] <= 3'b100
      |-> ##2 mode_out == $past(hwdata_in[4:2], 2))
      else $error("mode not taken");
endmodule
`default_nettype wire

// *** sim/tb_radio_measure_status_regs.sv ***
/* Bench top: bus tasks, a table of register cases, then triggers, flags,
   pin routing and a second reset. Assumes BIT_CYCLES of 4. */
`timescale 1ns/100ps
`default_nettype none
module tb_radio_measure_status_regs
  import rmsr_pkg::*;
;
  typedef struct packed {
    logic w;
    logic [7:0] idx, wd, exp;
  } rmsr_row_t;
  // Reset reads first, then write and read back
  localparam rmsr_row_t ROWS [15] = '{
    '{0, IDX_AFC_CTRL, 0, 8'h50}, '{0, IDX_LVL_CTRL, 0, 8'h02},
    '{0, IDX_LVL_VALUE, 0, 8'hff}, '{0, IDX_FLAGS_A, 0, 8'h80},
    '{0, IDX_THRESH, 0, 8'he4}, '{0, IDX_ROUTE_B, 0, 8'h07},
    '{0, IDX_ROUTE_A, 0, 8'h00}, '{1, IDX_ROUTE_A, 8'he4, 8'he4},
    '{1, IDX_ROUTE_B, 8'hff, 8'hf7}, '{1, IDX_ROUTE_B, 8'h46, 8'h46},
    '{1, IDX_THRESH, 8'h80, 8'h80}, '{1, IDX_AFC_HI, 8'h55, 8'h00},
    '{1, IDX_FEI_LO, 8'haa, 8'h00}, '{1, IDX_LVL_VALUE, 8'h00, 8'hff},
    '{1, 8'h3c, 8'h12, 8'h00}
  };
  localparam logic [7:0] RES [4] = '{8'h81, 8'h23, 8'hfe, 8'h01};
  logic clk_in, reset_in, hwrite, hready, rc_en, ce, fifo_e, hresp, clk_pin;
  logic rc_osc = 1'b0;
  logic [2:0] mode_o;
  logic xo, pll, pa, agc, inter, pkt, sync;
  logic lvl_go, afc_go, fei_go, lvl_ok, afc_ok, fei_ok;
  logic [1:0] htrans;
  logic [5:0] gp_pins;
  logic [15:0] lvl_v, afc_v, fei_v, lvl_res, afc_res, fei_res;
  logic [31:0] haddr, hwdata, hrdata, rv;
  int mismatches, checks_done;
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) rc_osc <= ~rc_osc;
  rmsr_regs #(.BIT_CYCLES(4)) DUT (
    .clk_in(clk_in), .reset_in(reset_in), .ce_in(ce), .hsel_in(1'b1),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .xo_running_in(xo), .pll_locked_in(pll), .pa_ramp_done_in(pa),
    .agc_done_in(agc), .inter_mode_in(inter), .packet_mode_in(pkt),
    .sync_detect_in(sync), .fifo_empty_in(fifo_e), .payload_ready_in(1'b0),
    .rc_osc_in(rc_osc), .lvl_sample_in(lvl_res[7:0]),
    .lvl_sample_valid_in(lvl_ok), .afc_result_in(afc_res),
    .afc_result_valid_in(afc_ok), .fei_result_in(fei_res),
    .fei_result_valid_in(fei_ok), .mode_out(mode_o), .afc_start_out(afc_go),
    .fei_start_out(fei_go), .lvl_start_out(lvl_go),
    .gp_out_pin_out(gp_pins), .clock_out_pin_out(clk_pin),
    .rc_osc_enable_out(rc_en)
  );
  rmsr_meas_model #(.DLY(12)) u_lvl (.clk_in(clk_in), .reset_in(reset_in),
    .start_in(lvl_go), .value_in(lvl_v), .result_out(lvl_res),
    .valid_out(lvl_ok));
  rmsr_meas_model #(.DLY(6)) u_afc (.clk_in(clk_in), .reset_in(reset_in),
    .start_in(afc_go), .value_in(afc_v), .result_out(afc_res),
    .valid_out(afc_ok));
  rmsr_meas_model #(.DLY(20)) u_fei (.clk_in(clk_in), .reset_in(reset_in),
    .start_in(fei_go), .value_in(fei_v), .result_out(fei_res),
    .valid_out(fei_ok));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Address phase, then data phase; each ends on a sampled ready
  task automatic bus(input logic w, input logic [7:0] idx, wd);
    int n;
    @(posedge clk_in);
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    for (int ph = 0; ph < 2; ph++) begin
      n = 0;
      do begin
        @(posedge clk_in);
        n++;
      end while (hready !== 1'b1 && n < 50);
      if (hready !== 1'b1) begin
        mismatches++;
        end_of_test();
      end
      htrans <= 2'b00;
      hwdata <= {24'hffffff, wd};
    end
    rv = hrdata;
  endtask
  task automatic poll(input logic [7:0] idx, input logic [31:0] want);
    int n;
    n = 0;
    do begin
      bus(1'b0, idx, 8'h00);
      n++;
    end while (rv !== want && n < 40);
    check("poll", rv, want);
  endtask
  initial begin
    reset_in = 1'b1;
    {haddr, hwdata, htrans, hwrite} = '0;
    {xo, pll, pa, agc, inter, pkt, sync, fifo_e} = '0;
    ce = 1'b1;
    {lvl_v, afc_v, fei_v} = '0;
    mismatches = 0;
    checks_done = 0;
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    foreach (ROWS[i]) begin
      if (ROWS[i].w)
        bus(1'b1, ROWS[i].idx, ROWS[i].wd);
      bus(1'b0, ROWS[i].idx, 8'h00);
      check("row", rv, {24'h0, ROWS[i].exp});
    end
    check("rc enable", {31'h0, rc_en}, 32'h1);
    @(negedge clk_in);
    check("clock rc", {31'h0, clk_pin}, {31'h0, ~rc_osc});
    // Code 000 toggles the pin on every clock
    bus(1'b1, IDX_ROUTE_B, 8'h40);
    @(negedge clk_in);
    rv = {31'h0, clk_pin};
    @(negedge clk_in);
    check("clock div", {31'h0, clk_pin}, ~rv & 32'h1);
    @(posedge clk_in);
    ce <= 1'b0;
    bus(1'b1, IDX_ROUTE_A, 8'h12);
    ce <= 1'b1;
    bus(1'b0, IDX_ROUTE_A, 8'h00);
    check("frozen", rv, 32'he4);
    lvl_v <= 16'h00a0;
    bus(1'b1, IDX_LVL_CTRL, 8'h01);
    bus(1'b0, IDX_LVL_CTRL, 8'h00);
    check("level busy", rv, 32'h0);
    poll(IDX_LVL_CTRL, 32'h2);
    bus(1'b0, IDX_LVL_VALUE, 8'h00);
    check("level value", rv, 32'ha0);
    afc_v <= 16'h8123;
    fei_v <= 16'hfe01;
    bus(1'b1, IDX_AFC_CTRL, 8'h21);
    bus(1'b0, IDX_AFC_CTRL, 8'h00);
    check("corr busy", rv, 32'h0);
    poll(IDX_AFC_CTRL, 32'h50);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 8'(IDX_AFC_HI + i), 8'h00);
      check("result byte", rv, {24'h0, RES[i]});
    end
    xo <= 1'b1;
    pll <= 1'b1;
    agc <= 1'b1;
    bus(1'b1, IDX_MODE, 8'h10);
    poll(IDX_FLAGS_A, 32'hd8);
    check("pin route", {26'h0, gp_pins}, 32'h15);
    // Packet mode keeps the sync flag, continuous mode lets it clear
    for (int pm = 1; pm >= 0; pm--) begin
      pkt <= pm[0];
      sync <= 1'b1;
      @(posedge clk_in);
      sync <= 1'b0;
      bus(1'b1, IDX_FLAGS_A, 8'h01);
      bus(1'b0, IDX_FLAGS_A, 8'h00);
      check("sync flag", rv, pm ? 32'hd9 : 32'hd8);
    end
    pa <= 1'b1;
    inter <= 1'b1;
    bus(1'b1, IDX_MODE, 8'h0c);
    poll(IDX_FLAGS_A, 32'hb2);
    pll <= 1'b0;
    inter <= 1'b0;
    bus(1'b1, IDX_MODE, 8'h04);
    poll(IDX_FLAGS_A, 32'h80);
    // Level below threshold, so the start timeout runs out
    lvl_v <= 16'h0010;
    bus(1'b1, IDX_TO_START, 8'h01);
    bus(1'b1, IDX_MODE, 8'h10);
    poll(IDX_FLAGS_A, 32'hc4);
    fifo_e <= 1'b1;
    bus(1'b0, IDX_FLAGS_A, 8'h00);
    check("fifo clear", rv, 32'hc0);
    reset_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    bus(1'b0, IDX_ROUTE_A, 8'h00);
    check("route after reset", rv, 32'h0);
    check("mode after reset", {29'h0, mode_o}, 32'h1);
    check("rc after reset", {31'h0, rc_en}, 32'h0);
    check("resp", {31'h0, hresp}, 32'h0);
    end_of_test();
  end
endmodule
bind rmsr_regs rmsr_regs_sva u_sva (
  .clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in), .hsel_in(hsel_in),
  .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
  .hwdata_in(hwdata_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
  .mode_out(mode_out), .afc_start_out(afc_start_out),
  .fei_start_out(fei_start_out), .lvl_start_out(lvl_start_out)
);
`default_nettype wire
